/* core/wt_pkg.sv */
// Purpose: Shared constants and types of the wake-up timer block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Byte address of a register is four times its index
package wt_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;
    localparam int IDX_W = 10;

    ////////////////////////////////////////////////////////////////////////
    // Register indices and byte addresses
    localparam logic [IDX_W-1:0] IDX_EXP_CFG = 10'h014;
    localparam logic [IDX_W-1:0] IDX_MANT_HI_CFG = 10'h015;
    localparam logic [IDX_W-1:0] IDX_MANT_LO_CFG = 10'h016;
    localparam logic [IDX_W-1:0] IDX_CNT_HI_LIVE = 10'h017;
    localparam logic [IDX_W-1:0] IDX_CNT_LO_LIVE = 10'h018;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h020;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h021;
    localparam logic [IDX_W-1:0] IDX_PIN_SEL = 10'h022;
    localparam logic [APB_AW-1:0] ADDR_EXP_CFG = {IDX_EXP_CFG, 2'b00};
    localparam logic [APB_AW-1:0] ADDR_MANT_HI_CFG = {IDX_MANT_HI_CFG, 2'b00};
    localparam logic [APB_AW-1:0] ADDR_MANT_LO_CFG = {IDX_MANT_LO_CFG, 2'b00};
    localparam logic [APB_AW-1:0] ADDR_CNT_HI_LIVE = {IDX_CNT_HI_LIVE, 2'b00};
    localparam logic [APB_AW-1:0] ADDR_CNT_LO_LIVE = {IDX_CNT_LO_LIVE, 2'b00};
    localparam logic [APB_AW-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [APB_AW-1:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
    localparam logic [APB_AW-1:0] ADDR_PIN_SEL = {IDX_PIN_SEL, 2'b00};

    ////////////////////////////////////////////////////////////////////////
    // Field layout
    localparam int EXP_W = 5;
    localparam int MANT_W = 16;
    localparam int BYTE_W = 8;
    localparam int IRQ_W = 1;
    localparam int IRQ_BIT_EXPIRED = 0;
    localparam int PIN_SEL_W = 5;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and the wake pin function code
    localparam logic [EXP_W-1:0] EXP_RESET = 5'h03;
    localparam logic [BYTE_W-1:0] MANT_HI_RESET = 8'h00;
    localparam logic [BYTE_W-1:0] MANT_LO_RESET = 8'h01;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 1'h0;
    localparam logic [PIN_SEL_W-1:0] PIN_SEL_RESET = 5'h00;
    localparam logic [PIN_SEL_W-1:0] PIN_FUNC_WAKE = 5'h01;

    ////////////////////////////////////////////////////////////////////////
    // Timing: interval = UNIT_TICKS * M * 2^R slow ticks, slow rate 32.768 kHz
    localparam int SLOW_CLK_HZ = 32768;
    localparam int UNIT_TICKS = 4;
    localparam logic [EXP_W-1:0] EXP_MAX = 5'h14;
    localparam int PRE_W = 22;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic [EXP_W-1:0] exponent;
        logic [MANT_W-1:0] mantissa;
    } wt_cfg_t;

    typedef enum logic [1:0] {
        WT_AP_IDLE = 2'b01,
        WT_AP_RESP = 2'b10
    } wt_ap_state_t;

endpackage

/* core/wt_sticky.sv */
// Purpose: Sticky event flags with write-one-to-clear
// Assumes: Set and clear are one-cycle requests on clk
// Notes: A set in the same cycle as a clear wins
`timescale 1ns/1ps
module wt_sticky #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] set_in,
    input wire logic [W-1:0] clr_in,
    output logic [W-1:0] flag_reg
);

    ////////////////////////////////////////////////////////////////////////
    // Flag storage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= (flag_reg & ~clr_in) | set_in;
        end
    end

endmodule

/* core/wt_unit_div.sv */
// Purpose: Divides slow ticks into mantissa units of 4 * 2^R ticks
// Assumes: Exponent already limited; tick is a one-cycle pulse on clk
// Notes: Cleared and silent while run is low
`timescale 1ns/1ps
module wt_unit_div
    import wt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic tick,
    input wire logic [EXP_W-1:0] exp_eff,
    output logic unit_done_reg
);

    logic [PRE_W-1:0] pre_reg;
    logic [PRE_W:0] span;
    logic [PRE_W:0] span_m1;
    logic [PRE_W-1:0] term;

    ////////////////////////////////////////////////////////////////////////
    // Unit length in ticks, minus one
    always_comb begin
        span = (PRE_W+1)'(UNIT_TICKS) << exp_eff; // RULE1
        span_m1 = span - (PRE_W+1)'(1);
        term = span_m1[PRE_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Tick counter
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_reg <= '0;
            unit_done_reg <= 1'b0;
        end else if (!run) begin
            pre_reg <= '0; // RULE13
            unit_done_reg <= 1'b0;
        end else if (tick && pre_reg >= term) begin
            pre_reg <= '0; // RULE12
            unit_done_reg <= 1'b1;
        end else begin
            pre_reg <= tick ? pre_reg + PRE_W'(1) : pre_reg;
            unit_done_reg <= 1'b0;
        end
    end

endmodule

/* core/wt_top.sv */
// Purpose: Wake-up timer with APB registers, expiry interrupt and pin output
// Assumes: lp_tick pulses once per 32.768 kHz period, synchronous to clk
// Notes: timer_en comes from the enable owner outside this block
//
// Operation
// RULE1: Interval is 4 * M * 2^R slow-clock periods, i.e. divided by 32.768 in ms.
// RULE2: Exponent sits in bits 4:0 of its register; bits 7:5 reserved.
// RULE3: Exponents above 20 behave exactly as 20.
// RULE4: Exponent zero is legal, giving units of four slow ticks.
// RULE5: Mantissa is built from a high byte and a low byte register.
// RULE6: Software never writes zero into the mantissa low byte.
// RULE7: Live count readable in two read-only bytes, high first; writes ignored.
// RULE8: Software disables the timer before changing settings, then re-enables.
// RULE9: Exponent resets to 00011; reserved bits have no defined value.
// RULE10: Mantissa high byte resets to zero.
// RULE11: Selectable pin function goes high once the timer has expired.
// RULE12: Count units, raise expiry when count reaches mantissa, then restart.
// RULE13: Timer halted and cleared while enable is low, starts from zero.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module wt_top
    import wt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic timer_en,
    input wire logic lp_tick,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [APB_DW-1:0] pwdata,
    output logic [APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic wake_pin
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    wt_cfg_t cfg_reg;
    wt_ap_state_t ap_state_reg;
    logic [APB_DW-1:0] prdata_reg;
    logic [APB_DW-1:0] rd_next;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;
    logic wake_pin_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic [PIN_SEL_W-1:0] pin_sel_reg;
    logic [MANT_W-1:0] count_reg;
    logic [MANT_W-1:0] count_inc;
    logic expire_reg;
    logic unit_done;
    logic [EXP_W-1:0] exp_eff;
    logic [IDX_W-1:0] idx;
    logic aligned;
    logic hit;
    logic wr_fire;
    logic take;
    logic expire_hit;
    logic sel_exp;
    logic sel_mant_hi;
    logic sel_mant_lo;
    logic sel_cnt_hi;
    logic sel_cnt_lo;
    logic sel_status;
    logic sel_mask;
    logic sel_pin;
    logic wr_exp;
    logic wr_mant_hi;
    logic wr_mant_lo;
    logic wr_status;
    logic wr_mask;
    logic wr_pin;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    assign idx = paddr[APB_AW-1:2];
    assign aligned = (paddr[1:0] == 2'b00);

    ////////////////////////////////////////////////////////////////////////
    // Register selects
    assign sel_exp = (idx == IDX_EXP_CFG);
    assign sel_mant_hi = (idx == IDX_MANT_HI_CFG);
    assign sel_mant_lo = (idx == IDX_MANT_LO_CFG);
    assign sel_cnt_hi = (idx == IDX_CNT_HI_LIVE);
    assign sel_cnt_lo = (idx == IDX_CNT_LO_LIVE);
    assign sel_status = (idx == IDX_IRQ_STATUS);
    assign sel_mask = (idx == IDX_IRQ_MASK);
    assign sel_pin = (idx == IDX_PIN_SEL);
    assign hit = aligned && (sel_exp || sel_mant_hi || sel_mant_lo || sel_cnt_hi
        || sel_cnt_lo || sel_status || sel_mask || sel_pin);

    ////////////////////////////////////////////////////////////////////////
    // Read data mux
    always_comb begin
        rd_next = '0;
        case (idx)
            IDX_EXP_CFG: begin
                rd_next[EXP_W-1:0] = cfg_reg.exponent; // RULE2
            end
            IDX_MANT_HI_CFG: begin
                rd_next[BYTE_W-1:0] = cfg_reg.mantissa[MANT_W-1:BYTE_W]; // RULE5
            end
            IDX_MANT_LO_CFG: begin
                rd_next[BYTE_W-1:0] = cfg_reg.mantissa[BYTE_W-1:0]; // RULE5
            end
            IDX_CNT_HI_LIVE: begin
                rd_next[BYTE_W-1:0] = count_reg[MANT_W-1:BYTE_W]; // RULE7
            end
            IDX_CNT_LO_LIVE: begin
                rd_next[BYTE_W-1:0] = count_reg[BYTE_W-1:0]; // RULE7
            end
            IDX_IRQ_STATUS: begin
                rd_next[IRQ_W-1:0] = irq_status;
            end
            IDX_IRQ_MASK: begin
                rd_next[IRQ_W-1:0] = irq_mask_reg;
            end
            IDX_PIN_SEL: begin
                rd_next[PIN_SEL_W-1:0] = pin_sel_reg;
            end
            default: begin
                rd_next = '0;
            end
        endcase
        if (!aligned) begin
            rd_next = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB handshake: one wait state, write lands on the edge with pready high
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ap_state_reg <= WT_AP_IDLE;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            case (ap_state_reg)
                WT_AP_IDLE: begin
                    if (take) begin
                        ap_state_reg <= WT_AP_RESP;
                        pready_reg <= 1'b1;
                        pslverr_reg <= !hit;
                        prdata_reg <= pwrite ? '0 : rd_next;
                    end
                end
                WT_AP_RESP: begin
                    ap_state_reg <= WT_AP_IDLE;
                    pready_reg <= 1'b0;
                    pslverr_reg <= 1'b0;
                    prdata_reg <= '0;
                end
                default: begin
                    ap_state_reg <= WT_AP_IDLE;
                    pready_reg <= 1'b0;
                    pslverr_reg <= 1'b0;
                    prdata_reg <= '0;
                end
            endcase
        end
    end

    assign take = (ap_state_reg == WT_AP_IDLE) && psel && penable;
    assign wr_fire = (ap_state_reg == WT_AP_RESP) && psel && penable && pwrite
        && !pslverr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Write strobes; live count indices have none
    assign wr_exp = wr_fire && sel_exp;
    assign wr_mant_hi = wr_fire && sel_mant_hi;
    assign wr_mant_lo = wr_fire && sel_mant_lo;
    assign wr_status = wr_fire && sel_status;
    assign wr_mask = wr_fire && sel_mask;
    assign wr_pin = wr_fire && sel_pin;

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers; live count indices have no write path
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_reg.exponent <= EXP_RESET; // RULE9
            cfg_reg.mantissa <= {MANT_HI_RESET, MANT_LO_RESET}; // RULE10
        end else begin
            if (wr_exp) begin
                cfg_reg.exponent <= pwdata[EXP_W-1:0]; // RULE2
            end
            if (wr_mant_hi) begin
                cfg_reg.mantissa[MANT_W-1:BYTE_W] <= pwdata[BYTE_W-1:0]; // RULE5
            end
            if (wr_mant_lo) begin
                cfg_reg.mantissa[BYTE_W-1:0] <= pwdata[BYTE_W-1:0]; // RULE5
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_mask_reg <= IRQ_MASK_RESET;
        end else if (wr_mask) begin
            irq_mask_reg <= pwdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_sel_reg <= PIN_SEL_RESET;
        end else if (wr_pin) begin
            pin_sel_reg <= pwdata[PIN_SEL_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Exponent limit and unit divider
    always_comb begin
        if (cfg_reg.exponent > EXP_MAX) begin
            exp_eff = EXP_MAX; // RULE3
        end else begin
            exp_eff = cfg_reg.exponent; // RULE4
        end
    end

    wt_unit_div u_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(timer_en),
        .tick(lp_tick),
        .exp_eff(exp_eff),
        .unit_done_reg(unit_done)
    ); // RULE4

    ////////////////////////////////////////////////////////////////////////
    // Mantissa counter and expiry; settings are live, software halts first
    assign count_inc = count_reg + MANT_W'(1);
    assign expire_hit = unit_done && (count_inc >= cfg_reg.mantissa);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_reg <= '0;
        end else if (!timer_en) begin
            count_reg <= '0; // RULE13
        end else if (expire_hit) begin
            count_reg <= '0; // RULE12
        end else if (unit_done) begin
            count_reg <= count_inc;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            expire_reg <= 1'b0;
        end else begin
            expire_reg <= timer_en && expire_hit; // RULE12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, mask and output
    always_comb begin
        irq_set = '0;
        irq_set[IRQ_BIT_EXPIRED] = expire_reg;
        irq_clr = wr_status ? pwdata[IRQ_W-1:0] : '0;
    end

    wt_sticky #(
        .W(IRQ_W)
    ) u_status (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_in(irq_set),
        .clr_in(irq_clr),
        .flag_reg(irq_status)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_status & irq_mask_reg);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wake_pin_reg <= 1'b0;
        end else begin
            wake_pin_reg <= (pin_sel_reg == PIN_FUNC_WAKE)
                && irq_status[IRQ_BIT_EXPIRED]; // RULE11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign wake_pin = wake_pin_reg;

endmodule

/* verif/wt_top_props.sv */
// Purpose: Concurrent checks on the wake-up timer ports
// Assumes: Single clock domain, sys_rst async active high
// Notes: Bound to wt_top at the foot of this file
`timescale 1ns/1ps
module wt_top_props
    import wt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic timer_en,
    input wire logic lp_tick,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [APB_DW-1:0] pwdata,
    input wire logic [APB_DW-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic wake_pin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////
    // Bus answer and interrupt cause
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("pready held beyond one cycle");
    AST_PREADY_AFTER_ACCESS: assert property ((psel && penable && !pready) |=> pready)
        else $error("pready late after access phase");
    AST_PREADY_CAUSE: assert property (pready |-> $past(psel && penable))
        else $error("pready without access");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr outside answer");
    AST_RDATA_IDLE_ZERO: assert property ((prdata != '0) |-> (pready && !pwrite))
        else $error("prdata nonzero outside read answer");
    AST_BYTE_WIDE: assert property (pready |-> (prdata[31:8] == '0))
        else $error("upper data bits not zero");
    AST_EXP_RESERVED: assert property ((pready && !pwrite && paddr == ADDR_EXP_CFG)
        |-> (prdata[31:5] == '0))
        else $error("reserved exponent bits read nonzero");
    AST_UNALIGNED_ERR: assert property ((pready && paddr[1:0] != 2'b00) |-> pslverr)
        else $error("unaligned access not refused");
    AST_IRQ_CAUSE: assert property ($rose(irq) |->
        ($past(timer_en, 4) || $past(pready) || $past(pready, 2)))
        else $error("irq rose while timer disabled");

    ////////////////////////////////////////////////////////////////////////
    // Scenario coverage
    COV_ERR: cover property (pslverr);
    COV_IRQ: cover property ($rose(irq));
    COV_PIN: cover property ($rose(wake_pin));
endmodule

bind wt_top wt_top_props i_wt_top_props (.clk(clk), .sys_rst(sys_rst),
    .timer_en(timer_en), .lp_tick(lp_tick), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .wake_pin(wake_pin));

/* verif/wt_top_test.sv */
// Purpose: Directed register and timing test of the wake-up timer
// Assumes: One wait state per APB transfer, ticks driven by the bench
// Notes: Exponent above 20 not timed; its periods are far too long
`timescale 1ns/1ps
module wt_top_test
    import wt_pkg::*;
;
    logic clk, sys_rst, timer_en, lp_tick, psel, penable, pwrite, pready, pslverr, irq, wake_pin;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata, prdata, rd;
    logic rerr;
    int err_count;
    int n_compared;

    wt_top i_wt_top (.clk(clk), .sys_rst(sys_rst), .timer_en(timer_en), .lp_tick(lp_tick),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .wake_pin(wake_pin));

    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Tasks
    task test_done;
        $display("Mismatches %0d, comparisons %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task check(input logic [APB_DW-1:0] seen, input logic [APB_DW-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic wr, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
        int i;
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            err_count++;
            $display("[FAIL] %0t bus answer timed out", $time);
            test_done();
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task wr(input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
        apb(1'b1, a, d);
    endtask

    task rdchk(input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] exp);
        apb(1'b0, a, '0);
        check(rd, exp);
    endtask

    task ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            lp_tick <= 1;
            @(posedge clk);
            lp_tick <= 0;
        end
        repeat (6) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Sequence
    initial begin
        sys_rst = 1;
        timer_en = 0;
        lp_tick = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = '0;
        pwdata = '0;
        err_count = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        sys_rst <= 0;
        // Reset values
        rdchk(ADDR_EXP_CFG, 32'h3);
        rdchk(ADDR_MANT_HI_CFG, 32'h0);
        rdchk(ADDR_MANT_LO_CFG, 32'h1);
        rdchk(ADDR_IRQ_STATUS, 32'h0);
        rdchk(ADDR_IRQ_MASK, 32'h0);
        rdchk(ADDR_CNT_HI_LIVE, 32'h0);
        // Field layout and refusals
        wr(ADDR_EXP_CFG, 32'hFF);
        rdchk(ADDR_EXP_CFG, 32'h1F);
        wr(ADDR_MANT_HI_CFG, 32'h12);
        wr(ADDR_MANT_LO_CFG, 32'h34);
        rdchk(ADDR_MANT_HI_CFG, 32'h12);
        rdchk(ADDR_MANT_LO_CFG, 32'h34);
        rdchk(12'h3FC, 32'h0);
        check({31'h0, rerr}, 32'h1);
        wr(12'h051, 32'h7);
        check({31'h0, rerr}, 32'h1);
        // Expiry after three units of four ticks
        wr(ADDR_EXP_CFG, 32'h0);
        wr(ADDR_MANT_HI_CFG, 32'h0);
        wr(ADDR_MANT_LO_CFG, 32'h3);
        wr(ADDR_IRQ_MASK, 32'h1);
        wr(ADDR_PIN_SEL, {27'h0, PIN_FUNC_WAKE});
        @(posedge clk);
        timer_en <= 1;
        ticks(4);
        rdchk(ADDR_CNT_LO_LIVE, 32'h1);
        wr(ADDR_CNT_LO_LIVE, 32'h55);
        rdchk(ADDR_CNT_LO_LIVE, 32'h1);
        ticks(7);
        rdchk(ADDR_IRQ_STATUS, 32'h0);
        check({31'h0, irq}, 32'h0);
        ticks(1);
        check({31'h0, irq}, 32'h1);
        check({31'h0, wake_pin}, 32'h1);
        rdchk(ADDR_IRQ_STATUS, 32'h1);
        rdchk(ADDR_CNT_LO_LIVE, 32'h0);
        // Mask and clear
        wr(ADDR_IRQ_MASK, 32'h0);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wr(ADDR_IRQ_STATUS, 32'h1);
        repeat (3) @(posedge clk);
        check({31'h0, wake_pin}, 32'h0);
        rdchk(ADDR_IRQ_STATUS, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h1);
        // Disable clears and halts the count
        ticks(4);
        rdchk(ADDR_CNT_LO_LIVE, 32'h1);
        @(posedge clk);
        timer_en <= 0;
        ticks(8);
        rdchk(ADDR_CNT_LO_LIVE, 32'h0);
        rdchk(ADDR_IRQ_STATUS, 32'h0);
        // Exponent one doubles the unit
        wr(ADDR_EXP_CFG, 32'h1);
        wr(ADDR_MANT_LO_CFG, 32'h1);
        @(posedge clk);
        timer_en <= 1;
        ticks(7);
        rdchk(ADDR_IRQ_STATUS, 32'h0);
        ticks(1);
        rdchk(ADDR_IRQ_STATUS, 32'h1);
        check({31'h0, irq}, 32'h1);
        // High mantissa byte counts; live count reaches its high byte
        @(posedge clk);
        timer_en <= 0;
        wr(ADDR_EXP_CFG, 32'h0);
        wr(ADDR_MANT_HI_CFG, 32'h1);
        wr(ADDR_MANT_LO_CFG, 32'h1);
        wr(ADDR_IRQ_STATUS, 32'h1);
        @(posedge clk);
        timer_en <= 1;
        ticks(1024);
        rdchk(ADDR_CNT_HI_LIVE, 32'h1);
        rdchk(ADDR_CNT_LO_LIVE, 32'h0);
        rdchk(ADDR_IRQ_STATUS, 32'h0);
        ticks(4);
        rdchk(ADDR_IRQ_STATUS, 32'h1);
        rdchk(ADDR_CNT_HI_LIVE, 32'h0);
        // Reset in mid-run restores the settings
        @(posedge clk);
        timer_en <= 0;
        sys_rst <= 1;
        repeat (2) @(posedge clk);
        sys_rst <= 0;
        rdchk(ADDR_EXP_CFG, 32'h3);
        rdchk(ADDR_MANT_HI_CFG, 32'h0);
        rdchk(ADDR_IRQ_STATUS, 32'h0);
        test_done();
    end
endmodule
